// ==== src/doc_pkg.sv ====
package doc_pkg;
   // Register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] DOC_OFF_AUX_MODE = 8'h00;
   localparam logic [7:0] DOC_OFF_FAULT_EN = 8'h04;
   localparam logic [7:0] DOC_OFF_STATUS = 8'h08;
   localparam logic [7:0] DOC_OFF_FDT_FREQ = 8'h0c;
   localparam logic [7:0] DOC_OFF_FDT_BW = 8'h10;
   localparam logic [7:0] DOC_OFF_OL_CFG = 8'h14;
   localparam logic [7:0] DOC_OFF_DELAY = 8'h18;
   localparam logic [7:0] DOC_OFF_FAN = 8'h1c;
   localparam logic [7:0] DOC_OFF_RETRY = 8'h20;
   // Reset values
   localparam logic [2:0] DOC_FAULT_EN_RST = 3'h2;
   localparam logic [7:0] DOC_STATUS_RST = 8'h00;
   localparam logic [4:0] DOC_MODE_RST = 5'h00;
   localparam logic [1:0] DOC_FAN_RST = 2'h0;
   // Fault enable bit positions
   localparam int DOC_FEN_LV = 0;
   localparam int DOC_FEN_TRIP = 1;
   localparam int DOC_FEN_RETRY = 2;
   // Status bit positions
   localparam int DOC_ST_EXTRA = 4;
   localparam int DOC_ST_RELAY = 7;
   // Timing
   localparam longint DOC_CLK_HZ = 20000000;
   localparam longint DOC_INTERLOCK_MS = 500;
   localparam longint DOC_INTERLOCK_CYC = DOC_INTERLOCK_MS * DOC_CLK_HZ / 1000;
   localparam longint DOC_IOL_S = 60;
   localparam longint DOC_IOL_CYC = DOC_IOL_S * DOC_CLK_HZ;
   localparam longint DOC_DELAY_TICK_MS = 100;
   localparam longint DOC_DELAY_TICK_CYC = DOC_DELAY_TICK_MS * DOC_CLK_HZ / 1000;
   localparam longint DOC_OL_TICK_MS = 100;
   localparam longint DOC_OL_TICK_CYC = DOC_OL_TICK_MS * DOC_CLK_HZ / 1000;
   localparam int DOC_IOL_PCT = 110;
   // Auxiliary contact condition codes
   typedef enum logic [4:0] {
      DOC_M_NONE, DOC_M_FDT1, DOC_M_FDT2, DOC_M_FDT3, DOC_M_FDT4, DOC_M_FDT5,
      DOC_M_OL, DOC_M_IOL, DOC_M_STALL, DOC_M_OV, DOC_M_LV, DOC_M_OH,
      DOC_M_LOST, DOC_M_RUN, DOC_M_STOP, DOC_M_STEADY, DOC_M_DRVLINE,
      DOC_M_MAINSLINE, DOC_M_SSEARCH, DOC_M_READY, DOC_M_MMC
   } doc_mode_e;
   typedef enum logic [1:0] {DOC_F_POWER, DOC_F_RUN, DOC_F_TEMP} doc_fan_e;
   typedef enum logic [1:0] {DOC_X_DRIVE, DOC_X_GAP1, DOC_X_MAINS, DOC_X_GAP2} doc_xchg_e;
endpackage

// ==== src/doc_output_contacts.sv ====
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module doc_output_contacts
   import doc_pkg::*;
#(
   parameter int FW = 16,
   parameter bit FAN_CTRL_PRESENT = 1'b1,
   parameter longint INTERLOCK_CYC = DOC_INTERLOCK_CYC,
   parameter longint IOL_CYC = DOC_IOL_CYC,
   parameter longint DELAY_TICK_CYC = DOC_DELAY_TICK_CYC,
   parameter longint OL_TICK_CYC = DOC_OL_TICK_CYC
) (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [FW-1:0] ref_freq_in,
   input wire logic [FW-1:0] out_freq_in,
   input wire logic [15:0] out_current_in,
   input wire logic [15:0] rated_current_in,
   input wire logic accel_in,
   input wire logic decel_in,
   input wire logic stall_in,
   input wire logic dc_bus_high_flag_in,
   input wire logic undervoltage_flag_in,
   input wire logic heatsink_hot_flag_in,
   input wire logic ref_lost_in,
   input wire logic running_in,
   input wire logic steady_in,
   input wire logic ssearch_in,
   input wire logic ready_in,
   input wire logic mmc_select_in,
   input wire logic [3:0] mmc_drive_in,
   input wire logic exchange_in,
   input wire logic general_trip_in,
   input wire logic emergency_disable_in,
   input wire logic retry_exhausted_in,
   input wire logic auto_retry_in,
   input wire logic over_temp_in,
   input wire logic [2:0] extra_output_in,
   output logic [3:0] aux_contact_output_out,
   output logic fault_relay_out,
   output logic drive_overload_flag_out,
   output logic drive_overload_trip_out,
   output logic fan_on_out
);
   // Configuration registers
   logic [4:0] aux_mode_r [4];
   logic [2:0] fault_relay_enable_r;
   logic [FW-1:0] fdt_freq_r;
   logic [FW-1:0] fdt_bw_r;
   logic [15:0] ol_level_r;
   logic [15:0] ol_time_r;
   logic [15:0] on_delay_r;
   logic [15:0] off_delay_r;
   logic [1:0] fan_sel_r;
   logic [7:0] output_terminal_status_r;

   // AXI4-Lite write path: address and data latched in either order
   logic aw_held_r, w_held_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic do_write;
   assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
   assign s_axi_awready = !aw_held_r;
   assign s_axi_wready = !w_held_r;
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && !aw_held_r) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held_r) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
         end
         if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Status offset and unmapped addresses answer SLVERR
            s_axi_bresp <= (aw_addr_r > DOC_OFF_RETRY || aw_addr_r == DOC_OFF_STATUS
                            || aw_addr_r[1:0] != 2'h0) ? 2'h2 : 2'h0;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register writes; byte strobes ignored except lane 0 gating
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < 4; i++) aux_mode_r[i] <= DOC_MODE_RST;
         fault_relay_enable_r <= DOC_FAULT_EN_RST;
         fdt_freq_r <= '0;
         fdt_bw_r <= '0;
         ol_level_r <= 16'h0000;
         ol_time_r <= 16'h0000;
         on_delay_r <= 16'h0000;
         off_delay_r <= 16'h0000;
         fan_sel_r <= DOC_FAN_RST;
      end else if (do_write && s_axi_wstrb[0]) begin
         unique case (aw_addr_r)
            DOC_OFF_AUX_MODE: for (int i = 0; i < 4; i++)
               aux_mode_r[i] <= w_data_r[8*i +: 5];
            DOC_OFF_FAULT_EN: fault_relay_enable_r <= w_data_r[2:0];
            DOC_OFF_FDT_FREQ: fdt_freq_r <= w_data_r[FW-1:0];
            DOC_OFF_FDT_BW: fdt_bw_r <= w_data_r[FW-1:0];
            DOC_OFF_OL_CFG: begin
               ol_level_r <= w_data_r[15:0];
               ol_time_r <= w_data_r[31:16];
            end
            DOC_OFF_DELAY: begin
               on_delay_r <= w_data_r[15:0];
               off_delay_r <= w_data_r[31:16];
            end
            DOC_OFF_FAN: if (FAN_CTRL_PRESENT) fan_sel_r <= w_data_r[1:0];
            default: ;
         endcase
      end
   end

   // Read path: one-cycle answer
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (s_axi_araddr)
         DOC_OFF_AUX_MODE: rd_mux = {3'h0, aux_mode_r[3], 3'h0, aux_mode_r[2],
                                     3'h0, aux_mode_r[1], 3'h0, aux_mode_r[0]};
         DOC_OFF_FAULT_EN: rd_mux = {29'h0, fault_relay_enable_r};
         DOC_OFF_STATUS: rd_mux = {24'h0, output_terminal_status_r};
         DOC_OFF_FDT_FREQ: rd_mux = 32'(fdt_freq_r);
         DOC_OFF_FDT_BW: rd_mux = 32'(fdt_bw_r);
         DOC_OFF_OL_CFG: rd_mux = {ol_time_r, ol_level_r};
         DOC_OFF_DELAY: rd_mux = {off_delay_r, on_delay_r};
         DOC_OFF_FAN: rd_mux = {30'h0, fan_sel_r};
         DOC_OFF_RETRY: rd_mux = {30'h0, drive_overload_trip_out, drive_overload_flag_out};
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= (s_axi_araddr > DOC_OFF_RETRY || s_axi_araddr[1:0] != 2'h0)
                        ? 2'h2 : 2'h0;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Frequency comparisons, widened by one bit to avoid overflow
   logic [FW:0] half_bw, diff_ref, diff_det, det_low;
   logic fdt1, fdt2, fdt3, fdt4_set, fdt4_r;
   assign half_bw = {1'b0, fdt_bw_r} >> 1;
   assign diff_ref = (ref_freq_in > out_freq_in) ? {1'b0, ref_freq_in - out_freq_in}
                                                  : {1'b0, out_freq_in - ref_freq_in};
   assign diff_det = (fdt_freq_r > out_freq_in) ? {1'b0, fdt_freq_r - out_freq_in}
                                                 : {1'b0, out_freq_in - fdt_freq_r};
   assign det_low = {1'b0, fdt_freq_r} - half_bw;
   assign fdt1 = diff_ref <= half_bw;
   assign fdt2 = fdt1 && (diff_det <= half_bw);
   assign fdt3 = diff_det <= half_bw;
   assign fdt4_set = out_freq_in >= fdt_freq_r;
   // Threshold state holds between accel set and decel release
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         fdt4_r <= 1'b0;
      end else if (accel_in) begin
         fdt4_r <= fdt4_set;
      end else if (decel_in) begin
         fdt4_r <= fdt4_r && ({1'b0, out_freq_in} > det_low);
      end else begin
         fdt4_r <= fdt4_r || fdt4_set;
      end
   end

   // Overload warning timer in ticks of OL_TICK_CYC
   logic [31:0] ol_pre_r;
   logic [15:0] ol_cnt_r;
   logic ol_warn_r;
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in || out_current_in < ol_level_r) begin
         ol_pre_r <= 32'h0;
         ol_cnt_r <= 16'h0;
         ol_warn_r <= 1'b0;
      end else if (ol_cnt_r >= ol_time_r) begin
         ol_warn_r <= 1'b1;
      end else if (ol_pre_r >= 32'(OL_TICK_CYC - 1)) begin
         ol_pre_r <= 32'h0;
         ol_cnt_r <= ol_cnt_r + 16'h1;
      end else begin
         ol_pre_r <= ol_pre_r + 32'h1;
      end
   end

   // Drive overload: 60 s over 110% flags, another minute trips
   logic over_110;
   logic [31:0] iol_cnt_r;
   assign over_110 = 32'(out_current_in) * 32'd100 > 32'(rated_current_in) * 32'(DOC_IOL_PCT);
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         iol_cnt_r <= 32'h0;
         drive_overload_flag_out <= 1'b0;
         drive_overload_trip_out <= 1'b0;
      end else if (!over_110) begin
         iol_cnt_r <= 32'h0;
         drive_overload_flag_out <= 1'b0;
      end else if (iol_cnt_r >= 32'(IOL_CYC - 1)) begin
         iol_cnt_r <= 32'h0;
         if (drive_overload_flag_out) drive_overload_trip_out <= 1'b1;
         drive_overload_flag_out <= 1'b1;
      end else begin
         iol_cnt_r <= iol_cnt_r + 32'h1;
      end
   end

   // Bypass exchange: drive line, gap, mains line, gap
   doc_xchg_e xstate_r;
   logic [31:0] xcnt_r;
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         xstate_r <= DOC_X_DRIVE;
         xcnt_r <= 32'h0;
      end else begin
         unique case (xstate_r)
            DOC_X_DRIVE: if (exchange_in) begin
               xstate_r <= DOC_X_GAP1;
               xcnt_r <= 32'h0;
            end
            DOC_X_GAP1: if (xcnt_r >= 32'(INTERLOCK_CYC - 1)) xstate_r <= DOC_X_MAINS;
                        else xcnt_r <= xcnt_r + 32'h1;
            DOC_X_MAINS: if (!exchange_in) begin
               xstate_r <= DOC_X_GAP2;
               xcnt_r <= 32'h0;
            end
            DOC_X_GAP2: if (xcnt_r >= 32'(INTERLOCK_CYC - 1)) xstate_r <= DOC_X_DRIVE;
                        else xcnt_r <= xcnt_r + 32'h1;
         endcase
      end
   end

   // Per-contact condition selection
   logic [3:0] aux_nxt;
   generate
      for (genvar g = 0; g < 4; g++) begin : g_aux
         doc_mode_e m;
         // Multi-motor selection overrides the programmed mode
         assign m = mmc_select_in ? DOC_M_MMC : doc_mode_e'(aux_mode_r[g]);
         always_comb begin
            unique case (m)
               DOC_M_FDT1: aux_nxt[g] = fdt1;
               DOC_M_FDT2: aux_nxt[g] = fdt2;
               DOC_M_FDT3: aux_nxt[g] = fdt3;
               DOC_M_FDT4: aux_nxt[g] = fdt4_r;
               DOC_M_FDT5: aux_nxt[g] = !fdt4_r;
               DOC_M_OL: aux_nxt[g] = ol_warn_r;
               DOC_M_IOL: aux_nxt[g] = drive_overload_flag_out;
               DOC_M_STALL: aux_nxt[g] = stall_in;
               DOC_M_OV: aux_nxt[g] = dc_bus_high_flag_in;
               DOC_M_LV: aux_nxt[g] = undervoltage_flag_in;
               DOC_M_OH: aux_nxt[g] = heatsink_hot_flag_in;
               DOC_M_LOST: aux_nxt[g] = ref_lost_in;
               DOC_M_RUN: aux_nxt[g] = running_in;
               DOC_M_STOP: aux_nxt[g] = !running_in;
               DOC_M_STEADY: aux_nxt[g] = steady_in;
               DOC_M_DRVLINE: aux_nxt[g] = xstate_r == DOC_X_DRIVE;
               DOC_M_MAINSLINE: aux_nxt[g] = xstate_r == DOC_X_MAINS;
               DOC_M_SSEARCH: aux_nxt[g] = ssearch_in;
               DOC_M_READY: aux_nxt[g] = ready_in;
               DOC_M_MMC: aux_nxt[g] = mmc_drive_in[g];
               default: aux_nxt[g] = 1'b0;
            endcase
         end
      end
   endgenerate
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) aux_contact_output_out <= 4'h0;
      else aux_contact_output_out <= aux_nxt;
   end

   // Fault relay request, checked in fixed priority order
   logic fault_req;
   always_comb begin
      if (fault_relay_enable_r[DOC_FEN_LV] && undervoltage_flag_in) fault_req = 1'b1;
      else if (fault_relay_enable_r[DOC_FEN_TRIP] && general_trip_in && !emergency_disable_in)
         fault_req = 1'b1;
      else if (fault_relay_enable_r[DOC_FEN_RETRY] && retry_exhausted_in && !auto_retry_in)
         fault_req = 1'b1;
      else fault_req = 1'b0;
   end

   // On/off delay in 0.1 s ticks; a change of request restarts the wait
   logic [31:0] dly_pre_r;
   logic [15:0] dly_cnt_r;
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in || fault_req == fault_relay_out) begin
         dly_pre_r <= 32'h0;
         dly_cnt_r <= 16'h0;
         if (!reset_n_in) fault_relay_out <= 1'b0;
      end else if (dly_cnt_r >= (fault_req ? on_delay_r : off_delay_r)) begin
         fault_relay_out <= fault_req;
      end else if (dly_pre_r >= 32'(DELAY_TICK_CYC - 1)) begin
         dly_pre_r <= 32'h0;
         dly_cnt_r <= dly_cnt_r + 16'h1;
      end else begin
         dly_pre_r <= dly_pre_r + 32'h1;
      end
   end

   // Fan selection; small variants keep the fan on with supply
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) fan_on_out <= 1'b0;
      else if (!FAN_CTRL_PRESENT) fan_on_out <= 1'b1;
      else unique case (doc_fan_e'(fan_sel_r))
         DOC_F_RUN: fan_on_out <= running_in;
         DOC_F_TEMP: fan_on_out <= over_temp_in;
         default: fan_on_out <= 1'b1;
      endcase
   end

   // Terminal status snapshot
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) output_terminal_status_r <= DOC_STATUS_RST;
      else output_terminal_status_r <= {fault_relay_out, extra_output_in,
                                        aux_contact_output_out};
   end

   // Checks
   a_lines_exclusive: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      !(xstate_r == DOC_X_DRIVE && xstate_r == DOC_X_MAINS) && !((aux_nxt != 4'h0) &&
      (xstate_r == DOC_X_GAP1) && aux_mode_r[0] == 5'(DOC_M_DRVLINE) && !mmc_select_in
      && aux_nxt[0])) else $error("Drive line closed in gap");
   a_none_open: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (aux_mode_r[0] == 5'h0 && !mmc_select_in) |=> !aux_contact_output_out[0])
      else $error("Unused contact closed");
   a_fdt1_close: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (aux_mode_r[1] == 5'(DOC_M_FDT1) && !mmc_select_in && fdt1) |=> aux_contact_output_out[1])
      else $error("Reference reached contact open");
   a_fdt5_inv: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (aux_mode_r[2] == 5'(DOC_M_FDT5) && !mmc_select_in) |=> aux_contact_output_out[2] == !$past(fdt4_r))
      else $error("Inverted threshold wrong");
   a_mmc_force: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      mmc_select_in |=> aux_contact_output_out == $past(mmc_drive_in))
      else $error("Multi-motor override missing");
   a_lv_relay: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (fault_relay_enable_r[DOC_FEN_LV] && undervoltage_flag_in) |-> fault_req)
      else $error("Undervoltage not routed");
   a_bx_block: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (emergency_disable_in && !undervoltage_flag_in && !retry_exhausted_in) |-> !fault_req)
      else $error("Emergency disable operated relay");
   a_retry_hold: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (auto_retry_in && !undervoltage_flag_in && !general_trip_in) |-> !fault_req)
      else $error("Retry relay during auto retry");
   a_status_map: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      ##1 output_terminal_status_r[DOC_ST_RELAY] == $past(fault_relay_out))
      else $error("Status bit 7 mismatch");
   a_fan_run: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (FAN_CTRL_PRESENT && fan_sel_r == 2'(DOC_F_RUN)) |=> fan_on_out == $past(running_in))
      else $error("Run fan mismatch");
endmodule // doc_output_contacts

// ==== tb/doc_contactor_model.sv ====
`timescale 1ns/1ns
// Far-side contactor pair for the bypass exchange; it records overlap and the open gap
module doc_contactor_model (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic drive_side_contactor_in,
   input wire logic mains_side_contactor_in,
   output logic overlap_out,
   output int gap_out
);
   // Both closed would short the drive output onto the mains, so it must never be seen
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         overlap_out <= 1'b0;
         gap_out <= 0;
      end else begin
         if (drive_side_contactor_in && mains_side_contactor_in) overlap_out <= 1'b1;
         if (drive_side_contactor_in) gap_out <= 0;
         else if (!mains_side_contactor_in) gap_out <= gap_out + 1;
      end
   end
endmodule // doc_contactor_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
   import doc_pkg::*;
   logic clk, rst_n, awv, wv, bre, arv, rre, awr, wr_, bv, arr, rv;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [1:0] bresp, rresp, r;
   logic [15:0] rf, of, cur, rat;
   logic acc, dec, stl, ovf, lvf, hot, lost, run, stdy, ss, rdy, mmc, xchg, trip, bx, rex, arty;
   logic otmp, rly, iolf, iolt, fan, ovl;
   logic [3:0] mmcd, aux;
   logic [2:0] xo;
   logic [8:0] stv;
   int miscompares, tests_run, gap;
   doc_mode_e ml[9] = '{DOC_M_STALL, DOC_M_OV, DOC_M_LV, DOC_M_OH, DOC_M_LOST, DOC_M_RUN,
      DOC_M_STEADY, DOC_M_SSEARCH, DOC_M_READY};
   logic [34:0] ft[5] = '{{16'd1000, 16'd995, 3'h7}, {16'd1000, 16'd994, 3'h0},
      {16'd1000, 16'd1005, 3'h7}, {16'd1100, 16'd1000, 3'h2}, {16'd1100, 16'd1100, 3'h1}};
   // Status inputs travel as one vector so a loop can raise one at a time
   assign {stl, ovf, lvf, hot, lost, run, stdy, ss, rdy} = stv;
   doc_output_contacts #(.INTERLOCK_CYC(10), .IOL_CYC(20), .DELAY_TICK_CYC(4),
      .OL_TICK_CYC(4)) DUT (.ref_clk_in(clk), .reset_n_in(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rre), .ref_freq_in(rf), .out_freq_in(of), .out_current_in(cur),
      .rated_current_in(rat), .accel_in(acc), .decel_in(dec), .stall_in(stl),
      .dc_bus_high_flag_in(ovf), .undervoltage_flag_in(lvf), .heatsink_hot_flag_in(hot),
      .ref_lost_in(lost), .running_in(run), .steady_in(stdy), .ssearch_in(ss),
      .ready_in(rdy), .mmc_select_in(mmc), .mmc_drive_in(mmcd), .exchange_in(xchg),
      .general_trip_in(trip), .emergency_disable_in(bx), .retry_exhausted_in(rex),
      .auto_retry_in(arty), .over_temp_in(otmp), .extra_output_in(xo),
      .aux_contact_output_out(aux), .fault_relay_out(rly), .drive_overload_flag_out(iolf),
      .drive_overload_trip_out(iolt), .fan_on_out(fan));
   doc_contactor_model partner (.ref_clk_in(clk), .reset_n_in(rst_n),
      .drive_side_contactor_in(aux[0]), .mains_side_contactor_in(aux[1]),
      .overlap_out(ovl), .gap_out(gap));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Address and data are released independently as each is taken
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      forever begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_) wv <= 1'b0;
         if (bv) break;
      end
      rs = bresp;
      bre <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      forever begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
         if (rv) break;
      end
      d = rdata;
      rs = rresp;
      rre <= 1'b0;
   endtask
   task pause(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Watchdog sized well above the longest sequence below
   initial begin
      pause(20000);
      miscompares++;
      final_report;
   end
   initial begin
      {awv, wv, bre, arv, rre, acc, dec, mmc, xchg, trip, bx, rex, arty, otmp} = '0;
      {awaddr, araddr, wdata, rf, of, cur, rat, mmcd, xo, stv} = '0;
      rst_n = 1'b0;
      pause(20);
      rst_n <= 1'b0 + 1'b1;
      pause(2);
      chk("fan", fan, 1);
      rd(DOC_OFF_FAULT_EN, v, r);
      chk("fault_en", v, 32'(DOC_FAULT_EN_RST));
      rd(8'h24, v, r);
      chk("unmapped", r, 2'h2);
      wr(DOC_OFF_STATUS, 32'hff, r);
      chk("status_wr", r, 2'h2);
      stv <= '1;
      pause(3);
      chk("none", aux, 0);
      xo <= 3'h5;
      for (int i = 0; i < 9; i++) begin
         wr(DOC_OFF_AUX_MODE, 32'(ml[i]), r);
         stv <= 9'h100 >> i;
         pause(3);
         chk("mode_on", aux[0], 1);
         stv <= ~(9'h100 >> i);
         pause(3);
         chk("mode_off", aux[0], 0);
      end
      // Ready input high so contact 0 (last mode: ready) reads back closed
      stv <= 9'h001;
      pause(3);
      rd(DOC_OFF_STATUS, v, r);
      chk("status", v, 32'h51);
      wr(DOC_OFF_FDT_FREQ, 32'd1000, r);
      wr(DOC_OFF_FDT_BW, 32'd10, r);
      wr(DOC_OFF_AUX_MODE, {3'h0, DOC_M_FDT2, 3'h0, DOC_M_FDT3, 3'h0, DOC_M_FDT1, 8'h0}, r);
      foreach (ft[i]) begin
         rf <= ft[i][34:19];
         of <= ft[i][18:3];
         pause(4);
         chk("freq", aux[3:1], ft[i][2:0]);
      end
      wr(DOC_OFF_AUX_MODE, {19'h0, DOC_M_MAINSLINE, 3'h0, DOC_M_DRVLINE}, r);
      pause(3);
      chk("line_rest", aux[1:0], 2'h1);
      // Exchange request is held steady, as a filtered input would be
      xchg <= 1'b1;
      for (int k = 0; k < 60 && aux[1] !== 1'b1; k++) pause(1);
      chk("line_mains", aux[1:0], 2'h2);
      chk("gap", 32'(gap >= 10), 1);
      xchg <= 1'b0;
      pause(40);
      chk("line_back", {ovl, aux[1:0]}, 3'h1);
      mmc <= 1'b1;
      mmcd <= 4'ha;
      pause(3);
      chk("mmc", aux, 4'ha);
      mmc <= 1'b0;
      wr(DOC_OFF_FAULT_EN, 32'h1, r);
      stv <= 9'h040;
      pause(8);
      chk("relay_lv", rly, 1);
      stv <= 9'h000;
      trip <= 1'b1;
      pause(8);
      chk("relay_masked", rly, 0);
      wr(DOC_OFF_FAULT_EN, 32'h2, r);
      pause(8);
      chk("relay_trip", rly, 1);
      // Trip stays raised so the disable really has something to mask
      bx <= 1'b1;
      pause(8);
      chk("relay_bx", rly, 0);
      bx <= 1'b0;
      trip <= 1'b0;
      wr(DOC_OFF_FAULT_EN, 32'h4, r);
      rex <= 1'b1;
      arty <= 1'b1;
      pause(8);
      chk("relay_auto", rly, 0);
      arty <= 1'b0;
      pause(8);
      rd(DOC_OFF_STATUS, v, r);
      chk("relay_retry", v[7], 1);
      rex <= 1'b0;
      pause(8);
      wr(DOC_OFF_DELAY, {16'd2, 16'd3}, r);
      rex <= 1'b1;
      pause(8);
      chk("on_delay", rly, 0);
      pause(12);
      chk("on_late", rly, 1);
      rex <= 1'b0;
      pause(4);
      chk("off_delay", rly, 1);
      pause(12);
      chk("off_late", rly, 0);
      wr(DOC_OFF_FAN, 32'h1, r);
      stv <= 9'h000;
      pause(3);
      chk("fan_run", fan, 0);
      wr(DOC_OFF_FAN, 32'h2, r);
      otmp <= 1'b1;
      pause(3);
      chk("fan_temp", fan, 1);
      cur <= 16'd111;
      rat <= 16'd100;
      pause(30);
      chk("iol", {iolt, iolf}, 2'h1);
      pause(30);
      chk("iol_trip", iolt, 1);
      // Overload warning: level 100, two ticks of hold time
      wr(DOC_OFF_OL_CFG, {16'd2, 16'd100}, r);
      wr(DOC_OFF_AUX_MODE, 32'(DOC_M_OL), r);
      cur <= 16'd50;
      pause(3);
      chk("ol_below", aux[0], 0);
      cur <= 16'd100;
      pause(4);
      chk("ol_early", aux[0], 0);
      pause(10);
      chk("ol_warn", aux[0], 1);
      // Threshold on contact 0, inverted threshold on contact 2
      wr(DOC_OFF_AUX_MODE, {11'h0, DOC_M_FDT5, 11'h0, DOC_M_FDT4}, r);
      acc <= 1'b1;
      of <= 16'd1000;
      pause(4);
      chk("fdt4_acc", {aux[2], aux[0]}, 2'h1);
      acc <= 1'b0;
      dec <= 1'b1;
      of <= 16'd996;
      pause(4);
      chk("fdt4_hold", {aux[2], aux[0]}, 2'h1);
      of <= 16'd995;
      pause(4);
      chk("fdt4_drop", {aux[2], aux[0]}, 2'h2);
      dec <= 1'b0;
      final_report;
   end
endmodule // tb_top
